// >>> rtl/tmf_frontend.sv
// Top of the transmit modulation front end control with APB register slave
`timescale 1ns/10ps
module tmf_frontend (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic transmit_bit_input,
  output logic transmit_bit_clock,
  input wire logic [1:0] agc_gain,
  output tmf_pkg::tmf_pa_type pa_out,
  output tmf_pkg::tmf_synth_type synth_out,
  output tmf_pkg::tmf_front_type front_out
);
  import tmf_pkg::*;

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == TX_CONFIG_OFFSET) || (addr == FRONT_END_OFFSET) ||
      (addr == REF_DIV_OFFSET) || (addr == STATUS_OFFSET);
  endfunction

  function automatic logic is_write(input logic [7:0] addr, input logic [7:0] target);
    is_write = psel && penable && pwrite && ce && (addr == target);
  endfunction

  logic [31:0] tx_config;
  logic [31:0] front_end;
  logic [2:0] ref_div;
  logic [31:0] status;
  logic [31:0] next_prdata;
  logic [2:0] eff_div;
  logic [2:0] ref_count;
  logic pfd_tick;
  logic [6:0] div_factor;
  logic [1:0] index_count;
  logic [8:0] period;
  logic sample_strobe;
  logic data_meta;
  logic data_sync;
  logic sampled_bit;
  logic [2:0] history;
  logic [2:0] shape;
  logic active;
  tmf_mod_type mode;
  logic [5:0] power_hi;
  logic [5:0] power_lo;
  logic [8:0] gaussian_on_off_keying_product;
  tmf_pa_type next_pa;
  tmf_synth_type next_synth;
  tmf_front_type next_front;

  // Polarity only means something for the amplitude-keyed schemes
  function automatic logic active_of(input logic bit_value);
    logic amplitude;
    amplitude = (tx_config[MOD_LSB +: 3] == MOD_ASK) || (tx_config[MOD_LSB +: 3] == MOD_OOK) ||
      (tx_config[MOD_LSB +: 3] == MOD_GAUSSIAN_ON_OFF_KEYING);
    active_of = amplitude ? (bit_value ^ tx_config[POLARITY_POS]) : bit_value;
  endfunction

  // APB slave: zero wait states while enabled, error on unmapped access
  assign pready = ce;
  assign pslverr = psel && penable && !is_mapped(paddr);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tx_config <= TX_CONFIG_RESET;
    end else if (is_write(paddr, TX_CONFIG_OFFSET)) begin
      tx_config <= pwdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      front_end <= FRONT_END_RESET;
    end else if (is_write(paddr, FRONT_END_OFFSET)) begin
      front_end <= pwdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ref_div <= REF_DIV_RESET;
    end else if (is_write(paddr, REF_DIV_OFFSET)) begin
      ref_div <= pwdata[2:0];
    end
  end

  assign status = {24'h00_0000, sampled_bit, transmit_bit_clock, shape, front_out.front_amp_gain_level, 1'b0};

  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      TX_CONFIG_OFFSET: next_prdata = tx_config;
      FRONT_END_OFFSET: next_prdata = front_end;
      REF_DIV_OFFSET: next_prdata = {29'h0000_0000, ref_div};
      STATUS_OFFSET: next_prdata = status;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup cycle so it stands through the access cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      prdata <= next_prdata;
    end
  end

  // Reference tick; a zero divide is taken as one
  assign eff_div = (ref_div == 3'h0) ? 3'h1 : ref_div;
  assign pfd_tick = ce && (ref_count >= eff_div - 3'h1);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ref_count <= 3'h0;
    end else if (ce) begin
      ref_count <= pfd_tick ? 3'h0 : ref_count + 3'h1;
    end
  end

  // Zero divider or index fields would stop the bit clock, so they count as one
  assign div_factor = (tx_config[DIV_FACTOR_LSB +: 7] == 7'h00) ? 7'h01 : tx_config[DIV_FACTOR_LSB +: 7];
  assign index_count = (tx_config[INDEX_LSB +: 2] == 2'h0) ? 2'h1 : tx_config[INDEX_LSB +: 2];
  assign period = {2'h0, div_factor} * {7'h00, index_count};

  tmf_bit_clock u_bit_clock (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .pfd_tick(pfd_tick),
    .period(period),
    .transmit_bit_clock(transmit_bit_clock),
    .sample_strobe(sample_strobe)
  );

  // The data pin is asynchronous to mclk
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      data_meta <= 1'b0;
      data_sync <= 1'b0;
    end else if (ce) begin
      data_meta <= transmit_bit_input;
      data_sync <= data_meta;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sampled_bit <= 1'b0;
      history <= 3'h0;
    end else if (sample_strobe) begin
      sampled_bit <= data_sync;
      history <= {history[1:0], active_of(data_sync)};
    end
  end

  // Binomial 1-2-1 kernel over three bits: a cheap Gaussian approximation, one bit of latency
  // Sum reaches 4, so every term is three bits wide
  assign shape = {2'h0, history[0]} + {1'h0, history[1], 1'h0} + {2'h0, history[2]};
  assign active = active_of(sampled_bit);
  assign power_hi = tx_config[POWER_HI_LSB +: 6];
  assign power_lo = tx_config[POWER_LO_LSB +: 6];
  assign gaussian_on_off_keying_product = {3'h0, power_hi} * {6'h00, shape};

  always_comb begin
    mode = MOD_FSK;
    unique case (tx_config[MOD_LSB +: 3])
      MOD_FSK: mode = MOD_FSK;
      MOD_GFSK: mode = MOD_GFSK;
      MOD_ASK: mode = MOD_ASK;
      MOD_OOK: mode = MOD_OOK;
      MOD_GAUSSIAN_ON_OFF_KEYING: mode = MOD_GAUSSIAN_ON_OFF_KEYING;
      default: mode = MOD_FSK;
    endcase
  end

  always_comb begin
    next_pa.enable = tx_config[PA_ENABLE_POS];
    next_pa.bias = tx_config[BIAS_LSB +: 2];
    next_pa.level = power_hi;
    unique case (mode)
      MOD_ASK: next_pa.level = active ? power_hi : power_lo;
      MOD_OOK: next_pa.level = active ? power_hi : 6'h00;
      MOD_GAUSSIAN_ON_OFF_KEYING: next_pa.level = gaussian_on_off_keying_product[7:2];
      default: next_pa.level = power_hi;
    endcase
    // Mute also on OOK inactive so the stage draws no current
    if (mode == MOD_OOK && !active) begin
      next_pa.enable = 1'b0;
    end
    if (!tx_config[PA_ENABLE_POS]) begin
      next_pa.level = 6'h00;
    end
  end

  always_comb begin
    next_synth.deviate = 1'b0;
    next_synth.dev_step = 9'h000;
    next_synth.dev_exp = 3'h0;
    next_synth.shape = 3'h0;
    if (mode == MOD_FSK) begin
      next_synth.deviate = sampled_bit;
      next_synth.dev_step = tx_config[DEV_STEP_LSB +: 9];
    end else if (mode == MOD_GFSK) begin
      next_synth.deviate = 1'b1;
      next_synth.dev_exp = tx_config[DEV_EXP_LSB +: 3];
      next_synth.shape = shape;
    end
  end

  always_comb begin
    next_front.input_short_switch = !front_end[TXRX_POS];
    next_front.front_amp_mode_select = front_end[AMP_MODE_POS];
    next_front.mixer_linearity = front_end[MIXER_LIN_POS];
    next_front.front_amp_gain_level = front_end[GAIN_MANUAL_POS] ?
      front_end[GAIN_LSB +: 2] : agc_gain;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pa_out <= '{enable: 1'b0, bias: PA_BIAS_RESET, level: 6'h00};
    end else if (ce) begin
      pa_out <= next_pa;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      synth_out <= '0;
    end else if (ce) begin
      synth_out <= next_synth;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      front_out <= '{input_short_switch: 1'b1, front_amp_mode_select: 1'b0, mixer_linearity: 1'b0,
        front_amp_gain_level: 2'h0};
    end else if (ce) begin
      front_out <= next_front;
    end
  end

  // Helper: cycles between reference ticks
  logic [2:0] tick_gap;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tick_gap <= 3'h1;
    end else if (ce) begin
      tick_gap <= pfd_tick ? 3'h1 : tick_gap + 3'h1;
    end
  end

  sequence strobe_s;
    sample_strobe;
  endsequence

  sequence shifted_s;
    history[0] == $past(active_of(data_sync)) && sampled_bit == $past(data_sync);
  endsequence

  fsk_power_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && tx_config[PA_ENABLE_POS] && (mode == MOD_FSK || mode == MOD_GFSK) |=> pa_out.level == $past(power_hi))
    else $error("frequency keyed power not primary");
  ask_level_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && tx_config[PA_ENABLE_POS] && mode == MOD_ASK && !active |=> pa_out.level == $past(power_lo))
    else $error("ask inactive level wrong");
  ook_mute_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && mode == MOD_OOK && !active |=> !pa_out.enable && pa_out.level == 6'h00)
    else $error("ook not muted");
  polarity_sel_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && mode == MOD_ASK && tx_config[PA_ENABLE_POS] && (sampled_bit ^ tx_config[POLARITY_POS])
    |=> pa_out.level == $past(power_hi))
    else $error("polarity not applied");
  bias_field_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ce |=> pa_out.bias == $past(tx_config[BIAS_LSB +: 2]))
    else $error("bias mismatch");
  pa_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && !tx_config[PA_ENABLE_POS] |=> !pa_out.enable && pa_out.level == 6'h00)
    else $error("amplifier not powered down");
  fsk_deviate_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && mode == MOD_FSK |=> synth_out.deviate == $past(sampled_bit) && synth_out.dev_step == $past(tx_config[23:15]))
    else $error("fsk deviation wrong");
  short_switch_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ce |=> front_out.input_short_switch == !$past(front_end[TXRX_POS]))
    else $error("input short switch wrong");
  ref_tick_a: assert property (@(posedge mclk) disable iff (!reset_n)
    pfd_tick && $stable(ref_div) |-> tick_gap == eff_div || $past(pfd_tick) == 1'b0 && tick_gap > eff_div)
    else $error("reference tick spacing wrong");
  sample_once_a: assert property (@(posedge mclk) disable iff (!reset_n)
    strobe_s |=> shifted_s)
    else $error("bit not sampled on strobe");

  sequence clock_rise_s;
    $rose(transmit_bit_clock);
  endsequence

  gfsk_exp_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && mode == MOD_GFSK |=> synth_out.deviate && synth_out.dev_exp == $past(tx_config[DEV_EXP_LSB +: 3]))
    else $error("gaussian deviation exponent wrong");
  gaussian_on_off_keying_full_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && tx_config[PA_ENABLE_POS] && mode == MOD_GAUSSIAN_ON_OFF_KEYING && history == 3'h7 |=> pa_out.level == $past(power_hi))
    else $error("gaussian on-off level not full on steady one");
  amp_mode_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ce |=> front_out.front_amp_mode_select == $past(front_end[AMP_MODE_POS]))
    else $error("front amplifier mode wrong");
  mixer_mode_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ce |=> front_out.mixer_linearity == $past(front_end[MIXER_LIN_POS]))
    else $error("mixer linearity wrong");
  gain_source_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && !front_end[GAIN_MANUAL_POS] |=> front_out.front_amp_gain_level == $past(agc_gain))
    else $error("gain level not from gain control");
  bit_rise_a: assert property (@(posedge mclk) disable iff (!reset_n)
    clock_rise_s |-> $past(pfd_tick))
    else $error("bit clock rose off a reference tick");
  strobe_low_a: assert property (@(posedge mclk) disable iff (!reset_n)
    sample_strobe && period > 9'h001 && $stable(period) |-> !transmit_bit_clock)
    else $error("data sampled while bit clock high");
endmodule // tmf_frontend

// >>> rtl/tmf_pkg.sv
// Package: constants, register map and carrier types of the transmit modulation front end
package tmf_pkg;
  localparam int CLK_PERIOD_NS = 25;
  // Register byte offsets
  localparam logic [7:0] TX_CONFIG_OFFSET = 8'h00;
  localparam logic [7:0] FRONT_END_OFFSET = 8'h04;
  localparam logic [7:0] REF_DIV_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  // Transmit configuration fields
  localparam int PA_ENABLE_POS = 4;
  localparam int MOD_LSB = 6;
  localparam int POWER_HI_LSB = 9;
  localparam int POWER_LO_LSB = 15;
  localparam int DEV_STEP_LSB = 15;
  localparam int DIV_FACTOR_LSB = 15;
  localparam int DEV_EXP_LSB = 24;
  localparam int INDEX_LSB = 27;
  localparam int POLARITY_POS = 29;
  localparam int BIAS_LSB = 30;
  // Front-end configuration fields
  localparam int GAIN_MANUAL_POS = 0;
  localparam int AMP_MODE_POS = 15;
  localparam int MIXER_LIN_POS = 18;
  localparam int GAIN_LSB = 20;
  localparam int TXRX_POS = 27;
  // Reset values; bias code 0 is the recommended 9 uA setting
  localparam logic [31:0] TX_CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] FRONT_END_RESET = 32'h0000_0000;
  localparam logic [2:0] REF_DIV_RESET = 3'h1;
  localparam logic [1:0] PA_BIAS_RESET = 2'h0;

  typedef enum logic [2:0] {
    MOD_FSK = 3'b000,
    MOD_GFSK = 3'b001,
    MOD_ASK = 3'b010,
    MOD_OOK = 3'b011,
    MOD_GAUSSIAN_ON_OFF_KEYING = 3'b100
  } tmf_mod_type;

  typedef struct packed {
    logic enable;
    logic [1:0] bias;
    logic [5:0] level;
  } tmf_pa_type;

  typedef struct packed {
    logic deviate;
    logic [8:0] dev_step;
    logic [2:0] dev_exp;
    logic [2:0] shape;
  } tmf_synth_type;

  typedef struct packed {
    logic input_short_switch;
    logic front_amp_mode_select;
    logic mixer_linearity;
    logic [1:0] front_amp_gain_level;
  } tmf_front_type;
endpackage

// >>> rtl/tmf_bit_clock.sv
// Transmit bit clock generator counting reference ticks per bit period
`timescale 1ns/10ps
module tmf_bit_clock (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic pfd_tick,
  input wire logic [8:0] period,
  output logic transmit_bit_clock,
  output logic sample_strobe
);
  import tmf_pkg::*;
  logic [8:0] count;
  logic [8:0] half;
  logic at_half;

  assign half = {1'b0, period[8:1]};
  assign at_half = pfd_tick && (count == half);
  // Sample mid-bit, away from the edge on which the controller shifts data
  assign sample_strobe = ce && at_half;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      count <= 9'h000;
    end else if (ce && pfd_tick) begin
      if (count >= period - 9'h001) begin
        count <= 9'h000;
      end else begin
        count <= count + 9'h001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      transmit_bit_clock <= 1'b0;
    end else if (ce && pfd_tick) begin
      transmit_bit_clock <= (count >= period - 9'h001) || (count < half - 9'h001);
    end
  end
endmodule // tmf_bit_clock

// >>> dv/tmf_mcu_model.sv
// Microcontroller model that shifts a bit pattern out on the transmit bit clock
`timescale 1ns/10ps
module tmf_mcu_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic transmit_bit_clock,
  input wire logic [7:0] pattern,
  output logic transmit_bit_input
);
  logic last_clk;
  logic [2:0] idx;
  // Data changes just after the bit clock rises, so it is settled at the mid-period sample
  always @(posedge mclk) begin
    last_clk <= transmit_bit_clock;
    if (!reset_n) begin
      idx <= 3'h0;
      transmit_bit_input <= 1'b0;
    end else if (transmit_bit_clock && !last_clk) begin
      transmit_bit_input <= pattern[idx];
      idx <= idx + 3'h1;
    end
  end
endmodule // tmf_mcu_model

// >>> dv/tx_modulation_frontend_control_bench.sv
// Self-checking bench for the transmit modulation front end control
`timescale 1ns/10ps
module tx_modulation_frontend_control_bench;
  import tmf_pkg::*;
  typedef struct packed {
    logic [2:0] m;
    logic pol;
    logic en;
    logic d;
    logic [8:0] pa;
    logic dev;
  } tmf_row_type;
  // Mode, polarity, enable, data level, expected amplifier word, expected deviate
  localparam tmf_row_type ROWS [14] = '{
    '{3'h0, 1'b0, 1'b1, 1'b0, 9'h1AA, 1'b0}, '{3'h0, 1'b0, 1'b1, 1'b1, 9'h1AA, 1'b1},
    '{3'h1, 1'b0, 1'b1, 1'b0, 9'h1AA, 1'b1}, '{3'h2, 1'b0, 1'b1, 1'b0, 9'h184, 1'b0},
    '{3'h2, 1'b0, 1'b1, 1'b1, 9'h1AA, 1'b0}, '{3'h2, 1'b1, 1'b1, 1'b1, 9'h184, 1'b0},
    '{3'h2, 1'b1, 1'b1, 1'b0, 9'h1AA, 1'b0}, '{3'h3, 1'b0, 1'b1, 1'b1, 9'h1AA, 1'b0},
    '{3'h3, 1'b0, 1'b1, 1'b0, 9'h080, 1'b0}, '{3'h3, 1'b1, 1'b1, 1'b0, 9'h1AA, 1'b0},
    '{3'h4, 1'b0, 1'b1, 1'b1, 9'h1AA, 1'b0}, '{3'h0, 1'b0, 1'b0, 1'b1, 9'h080, 1'b1},
    '{3'h5, 1'b0, 1'b1, 1'b1, 9'h1AA, 1'b1}, '{3'h1, 1'b0, 1'b1, 1'b1, 9'h1AA, 1'b1}};
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [1:0] agc_gain = 2'h3;
  logic [7:0] pattern = 8'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic transmit_bit_input;
  logic transmit_bit_clock;
  tmf_pa_type pa_out;
  tmf_synth_type synth_out;
  tmf_front_type front_out;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] cfg;
  logic [31:0] rd;
  logic er;
  logic prev;
  int n;

  always #12.5 mclk = ~mclk;

  tmf_frontend i_dut (.mclk(mclk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .transmit_bit_input(transmit_bit_input), .transmit_bit_clock(transmit_bit_clock),
    .agc_gain(agc_gain), .pa_out(pa_out), .synth_out(synth_out), .front_out(front_out));

  tmf_mcu_model i_mcu (.mclk(mclk), .reset_n(reset_n), .transmit_bit_clock(transmit_bit_clock),
    .pattern(pattern), .transmit_bit_input(transmit_bit_input));

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts clock edges until the next rising edge of the bit clock
  task automatic wait_rise(output int k);
    k = 0;
    while (transmit_bit_clock !== 1'b0 && k < 200) begin @(posedge mclk); k++; end
    while (transmit_bit_clock !== 1'b1 && k < 200) begin @(posedge mclk); k++; end
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    repeat (15) @(posedge mclk);
    @(negedge mclk);
    chk("reset pa", 32'h0, {23'h0, pa_out});
    chk("reset synth", 32'h0, {16'h0, synth_out});
    chk("reset front", 32'h10, {27'h0, front_out});
    @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk("front after reset", 32'h13, {27'h0, front_out});
    apb(1'b0, REF_DIV_OFFSET, 32'h0, rd, er);
    chk("ref div reset", 32'h1, rd);
    chk("mapped err", 32'h0, {31'h0, er});
    apb(1'b0, 8'h10, 32'h0, rd, er);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    $display("test reset and map done");
    for (int i = 0; i < 14; i++) begin
      cfg = {2'b10, ROWS[i].pol, 2'b10, 3'h3, 3'h0, 6'h04, 6'h2A, ROWS[i].m, 1'b0, ROWS[i].en, 4'h0};
      pattern <= {8{ROWS[i].d}};
      apb(1'b1, TX_CONFIG_OFFSET, cfg, rd, er);
      repeat (100) @(posedge mclk);
      chk("pa_out", {23'h0, ROWS[i].pa}, {23'h0, pa_out});
      if (ROWS[i].m < 3'h2 || ROWS[i].m > 3'h4) begin
        chk("deviate", {31'h0, ROWS[i].dev}, {31'h0, synth_out.deviate});
        chk("dev_step", (ROWS[i].m == 3'h1) ? 32'h0 : {23'h0, cfg[23:15]}, {23'h0, synth_out.dev_step});
        chk("dev_exp", (ROWS[i].m == 3'h1) ? {29'h0, cfg[26:24]} : 32'h0, {29'h0, synth_out.dev_exp});
        chk("shape", (ROWS[i].m == 3'h1 && ROWS[i].d) ? 32'h4 : 32'h0, {29'h0, synth_out.shape});
      end
    end
    apb(1'b0, TX_CONFIG_OFFSET, 32'h0, rd, er);
    chk("config readback", cfg, rd);
    $display("test modulation rows done");
    pattern <= 8'h55;
    apb(1'b1, TX_CONFIG_OFFSET, 32'h9202_5410, rd, er);
    repeat (100) @(posedge mclk);
    wait_rise(n);
    prev = synth_out.deviate;
    for (int i = 0; i < 6; i++) begin
      wait_rise(n);
      chk("bit period", 32'd8, n);
      chk("toggle", {31'h0, ~prev}, {31'h0, synth_out.deviate});
      prev = synth_out.deviate;
    end
    apb(1'b1, REF_DIV_OFFSET, 32'h3, rd, er);
    wait_rise(n);
    wait_rise(n);
    chk("divided period", 32'd24, n);
    apb(1'b1, REF_DIV_OFFSET, 32'h1, rd, er);
    $display("test bit clock done");
    apb(1'b1, FRONT_END_OFFSET, 32'h0824_8001, rd, er);
    repeat (3) @(posedge mclk);
    chk("front manual", 32'h0E, {27'h0, front_out});
    apb(1'b1, FRONT_END_OFFSET, 32'h0014_0000, rd, er);
    repeat (3) @(posedge mclk);
    chk("front agc", 32'h17, {27'h0, front_out});
    $display("test front end done");
    ce <= 1'b0;
    agc_gain <= 2'h1;
    @(posedge mclk);
    @(negedge mclk);
    chk("pready hold", 32'h0, {31'h0, pready});
    repeat (3) @(posedge mclk);
    chk("front frozen", 32'h17, {27'h0, front_out});
    ce <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("front agc update", 32'h15, {27'h0, front_out});
    $display("test clock enable done");
    test_done();
  end
endmodule // tx_modulation_frontend_control_bench
